// ### logic/swpc_map.svh
// Constants for the wake and power sequencer: timing counts and resets.
// Assumes a 100 MHz always-on clock from the standby rail.
`ifndef SWPC_MAP_SVH
`define SWPC_MAP_SVH

// Clock period in ns
`define SWPC_CLK_NS 10
// Long-press threshold of the power switch, in ms
`define SWPC_LONG_PRESS_MS 4000
// Long-press threshold in clock cycles; ordered to stay inside 32 bits
`define SWPC_LONG_PRESS_CYC \
    (((`SWPC_LONG_PRESS_MS * 1000) / `SWPC_CLK_NS) * 1000)
// Supply settle time after power good in the working state, in us
`define SWPC_SETTLE_US 100
// Settle time in clock cycles
`define SWPC_SETTLE_CYC ((`SWPC_SETTLE_US * 1000) / `SWPC_CLK_NS)
// Width of the press and settle counters
`define SWPC_CNT_W 32
// Reset value of the remembered power state (off)
`define SWPC_LAST_ON_RST 1'b0
// Number of wake sources
`define SWPC_NWAKE 7
// Wake source bit positions
`define SWPC_WK_LAN 0
`define SWPC_WK_RI 1
`define SWPC_WK_RING 2
`define SWPC_WK_USB 3
`define SWPC_WK_KBD 4
`define SWPC_WK_PME 5
`define SWPC_WK_RTC 6

`endif

// ### logic/swpc_pkg.sv
// Types for the wake and power sequencer.
// Assumes swpc_map.svh defines the constants.
package swpc_pkg;
    // Power states seen by the board
    typedef enum logic [2:0] {
        SWPC_G3,
        SWPC_S0,
        SWPC_S1,
        SWPC_S3,
        SWPC_S5,
        SWPC_APM_SLEEP,
        SWPC_APM_OFF
    } swpc_pstate_type;

    // Commands that firmware may issue
    typedef enum logic [2:0] {
        SWPC_CMD_NONE,
        SWPC_CMD_OFF,
        SWPC_CMD_S1,
        SWPC_CMD_S3,
        SWPC_CMD_APM_SLEEP
    } swpc_cmd_type;
endpackage

// ### logic/swpc_core.sv
// Wake and power sequencer: supply, fans, indicator and wake sources.
// Assumes an always-on clock; firmware gives one-cycle command strobes.
//
// Overview of operation
// - Valid power-down command switches supply off
// - After outage restore previous on/off state when soft-off is enabled
// - Switch supply and fans, accept tachometers
// - LAN connector wakes only from soft-off
// - S3 keeps supply, fans off; amber LED
// - Wake in S3 returns to working state
// - Ring wakes from APM off or S3
// - First call restores power, second accesses
// - Serial ring for external, connector internal, in APM off or S3
// - Serial ring resumes from APM sleep or S1 with either modem type; connector ring does not
// - USB activity wakes from S1 or S3
// - Keyboard activity wakes from S1 or S3
// - PME assertion wakes from S1 or S3
// - Long press forces off, short sleeps
`include "swpc_map.svh"

module swpc_core #(
    parameter logic [31:0] LONG_PRESS_CYC = `SWPC_LONG_PRESS_CYC,
    parameter logic [31:0] SETTLE_CYC = `SWPC_SETTLE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic soft_off_en_i,
    input wire logic ac_present_i,
    input wire logic power_good_i,
    input wire swpc_pkg::swpc_cmd_type cmd_i,
    input wire logic cmd_valid_i,
    input wire logic acpi_mode_i,
    input wire logic led_dual_i,
    input wire logic ext_modem_i,
    input wire logic pwr_btn_n_i,
    input wire logic lan_wake_n_i,
    input wire logic serial_ri_i,
    input wire logic ring_wake_n_i,
    input wire logic usb_wake_i,
    input wire logic kbd_wake_i,
    input wire logic pme_n_i,
    input wire logic rtc_alarm_i,
    input wire logic sys_fan_tach_i,
    input wire logic psu_fan_tach_i,
    output logic psu_on_n_o,
    output logic sys_fan_on_o,
    output logic psu_fan_on_o,
    output logic led_green_o,
    output logic led_amber_o,
    output logic sys_running_o,
    output logic ring_first_call_o,
    output logic sys_fan_tach_o,
    output logic psu_fan_tach_o,
    output swpc_pkg::swpc_pstate_type pstate_o
);
    import swpc_pkg::*;

    localparam int NW = `SWPC_NWAKE;

    logic [NW-1:0] raw_wake;
    logic [NW-1:0] wake_s1;
    logic [NW-1:0] wake_s2;
    logic [NW-1:0] wake_q;
    logic [NW-1:0] wake_pend;
    logic [NW-1:0] wake_allow;
    logic [2:0] misc_s1;
    logic [2:0] misc_s2;
    logic btn_q;
    logic ac_q;
    logic [1:0] tach_s1;
    logic [1:0] tach_s2;
    logic [`SWPC_CNT_W-1:0] press_cnt;
    logic [`SWPC_CNT_W-1:0] settle_cnt;
    logic long_fired;
    logic last_on;
    logic ring_armed;
    logic wake_go;
    logic press_short;
    logic press_long;
    swpc_pstate_type pstate;
    swpc_pstate_type next_pstate;

    // Wake inputs gathered active high
    always_comb begin
        raw_wake = '0;
        raw_wake[`SWPC_WK_LAN] = ~lan_wake_n_i;
        raw_wake[`SWPC_WK_RI] = serial_ri_i;
        raw_wake[`SWPC_WK_RING] = ~ring_wake_n_i;
        raw_wake[`SWPC_WK_USB] = usb_wake_i;
        raw_wake[`SWPC_WK_KBD] = kbd_wake_i;
        raw_wake[`SWPC_WK_PME] = ~pme_n_i;
        raw_wake[`SWPC_WK_RTC] = rtc_alarm_i;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_s1 <= '0;
            wake_s2 <= '0;
            wake_q <= '0;
            misc_s1 <= 3'h0;
            misc_s2 <= 3'h0;
            tach_s1 <= 2'h0;
            tach_s2 <= 2'h0;
        end else begin
            wake_s1 <= raw_wake;
            wake_s2 <= wake_s1;
            wake_q <= wake_s2;
            misc_s1 <= {~pwr_btn_n_i, ac_present_i, power_good_i};
            misc_s2 <= misc_s1;
            tach_s1 <= {psu_fan_tach_i, sys_fan_tach_i};
            tach_s2 <= tach_s1;
        end
    end

    assign sys_fan_tach_o = tach_s2[0];
    assign psu_fan_tach_o = tach_s2[1];

    // Which sources may wake the present state
    always_comb begin
        wake_allow = '0;
        case (pstate)
            SWPC_S1, SWPC_APM_SLEEP: begin
                // serial ring, keyboard and RTC resume, on one call; USB and PME only from S1
                wake_allow[`SWPC_WK_RI] = 1'b1;
                wake_allow[`SWPC_WK_USB] = pstate == SWPC_S1;
                wake_allow[`SWPC_WK_KBD] = 1'b1;
                wake_allow[`SWPC_WK_PME] = pstate == SWPC_S1;
                wake_allow[`SWPC_WK_RTC] = 1'b1;
            end
            SWPC_S3: begin
                // ring source chosen by modem type
                wake_allow[`SWPC_WK_RI] = ext_modem_i;
                wake_allow[`SWPC_WK_RING] = ~ext_modem_i;
                wake_allow[`SWPC_WK_USB] = 1'b1;
                wake_allow[`SWPC_WK_KBD] = 1'b1;
                wake_allow[`SWPC_WK_PME] = 1'b1;
                wake_allow[`SWPC_WK_RTC] = 1'b1;
            end
            SWPC_S5, SWPC_APM_OFF: begin
                wake_allow[`SWPC_WK_LAN] = 1'b1;
                // ring wake only from APM off
                wake_allow[`SWPC_WK_RI] = (pstate == SWPC_APM_OFF)
                    && ext_modem_i;
                wake_allow[`SWPC_WK_RING] = (pstate == SWPC_APM_OFF)
                    && ~ext_modem_i;
                wake_allow[`SWPC_WK_PME] = pstate == SWPC_S5;
                wake_allow[`SWPC_WK_RTC] = pstate == SWPC_S5;
            end
            default: wake_allow = '0;
        endcase
    end

    // rising edge latched until power is back; set beats clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_pend <= '0;
        end else if (pstate == SWPC_S0) begin
            wake_pend <= wake_s2 & ~wake_q & wake_allow;
        end else begin
            wake_pend <= wake_pend | (wake_s2 & ~wake_q & wake_allow);
        end
    end

    assign wake_go = |wake_pend;

    // Power switch press timer
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            btn_q <= 1'b0;
            press_cnt <= '0;
            long_fired <= 1'b0;
        end else begin
            btn_q <= misc_s2[2];
            if (!misc_s2[2]) begin
                press_cnt <= '0;
                long_fired <= 1'b0;
            end else if (press_cnt < LONG_PRESS_CYC) begin
                press_cnt <= press_cnt + 1'b1;
            end else begin
                long_fired <= 1'b1;
            end
        end
    end

    // long press acts while held; short press on release
    assign press_long = misc_s2[2] && (press_cnt >= LONG_PRESS_CYC)
        && !long_fired;
    assign press_short = btn_q && !misc_s2[2] && !long_fired
        && (press_cnt < LONG_PRESS_CYC);

    // Supply return edge detector
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ac_q <= 1'b0;
        end else begin
            ac_q <= misc_s2[1];
        end
    end

    // Next power state
    always_comb begin
        next_pstate = pstate;
        case (pstate)
            SWPC_G3: begin
                if (misc_s2[1] && !ac_q) begin
                    if (soft_off_en_i && last_on) begin
                        next_pstate = SWPC_S0;
                    end else begin
                        next_pstate = acpi_mode_i ? SWPC_S5 : SWPC_APM_OFF;
                    end
                end
            end
            SWPC_S0: begin
                if (press_long) begin
                    next_pstate = acpi_mode_i ? SWPC_S5 : SWPC_APM_OFF;
                end else if (press_short) begin
                    next_pstate = acpi_mode_i ? SWPC_S1 : SWPC_APM_SLEEP;
                end else if (cmd_valid_i) begin
                    case (cmd_i)
                        SWPC_CMD_OFF: if (soft_off_en_i) begin
                            next_pstate = acpi_mode_i ? SWPC_S5
                                : SWPC_APM_OFF;
                        end
                        SWPC_CMD_S1: next_pstate = SWPC_S1;
                        SWPC_CMD_S3: next_pstate = SWPC_S3;
                        SWPC_CMD_APM_SLEEP: next_pstate = SWPC_APM_SLEEP;
                        default: next_pstate = pstate;
                    endcase
                end
            end
            SWPC_S1, SWPC_S3, SWPC_APM_SLEEP: begin
                // any permitted wake returns to working
                if (press_long) begin
                    next_pstate = acpi_mode_i ? SWPC_S5 : SWPC_APM_OFF;
                end else if (wake_go || press_short) begin
                    next_pstate = SWPC_S0;
                end
            end
            SWPC_S5, SWPC_APM_OFF: begin
                if (wake_go || press_short) begin
                    next_pstate = SWPC_S0;
                end
            end
            default: next_pstate = SWPC_G3;
        endcase
        // Loss of mains overrides everything
        if (!misc_s2[1]) begin
            next_pstate = SWPC_G3;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pstate <= SWPC_G3;
        end else begin
            pstate <= next_pstate;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_on <= `SWPC_LAST_ON_RST;
        end else if (pstate != SWPC_G3) begin
            last_on <= (pstate != SWPC_S5) && (pstate != SWPC_APM_OFF);
        end
    end

    // ring from S3 or APM off only restores power; flag for second call
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ring_armed <= 1'b0;
        end else if ((pstate == SWPC_S3 || pstate == SWPC_APM_OFF)
            && (wake_pend[`SWPC_WK_RI] || wake_pend[`SWPC_WK_RING])) begin
            ring_armed <= 1'b1;
        end else if (pstate != SWPC_S0) begin
            ring_armed <= 1'b0;
        end
    end

    // Settle timer before reporting the system running
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_cnt <= '0;
        end else if (pstate != SWPC_S0 || !misc_s2[0]) begin
            settle_cnt <= '0;
        end else if (settle_cnt < SETTLE_CYC) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // supply, fans and indicator from the state
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psu_on_n_o <= 1'b1;
            sys_fan_on_o <= 1'b0;
            psu_fan_on_o <= 1'b0;
            led_green_o <= 1'b0;
            led_amber_o <= 1'b0;
            sys_running_o <= 1'b0;
            ring_first_call_o <= 1'b0;
            pstate_o <= SWPC_G3;
        end else begin
            // S1 keeps the rail up: the CPU is only stopped
            psu_on_n_o <= !(next_pstate == SWPC_S0
                || next_pstate == SWPC_S1
                || next_pstate == SWPC_APM_SLEEP);
            sys_fan_on_o <= next_pstate == SWPC_S0;
            psu_fan_on_o <= next_pstate == SWPC_S0;
            led_green_o <= next_pstate == SWPC_S0;
            led_amber_o <= led_dual_i && (next_pstate == SWPC_S3
                || next_pstate == SWPC_S1
                || next_pstate == SWPC_APM_SLEEP);
            sys_running_o <= settle_cnt >= SETTLE_CYC;
            ring_first_call_o <= ring_armed;
            pstate_o <= next_pstate;
        end
    end
endmodule

// ### test/swpc_checker.sv
// Assertions on the ports of the wake and power sequencer.
// Assumes wake sources hold their level for several clock cycles.
module swpc_checker
    import swpc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire swpc_pkg::swpc_pstate_type pstate_o,
    input wire logic psu_on_n_o,
    input wire logic sys_fan_on_o,
    input wire logic psu_fan_on_o,
    input wire logic led_amber_o,
    input wire logic led_dual_i,
    input wire logic ext_modem_i,
    input wire logic lan_wake_n_i,
    input wire logic usb_wake_i,
    input wire logic kbd_wake_i,
    input wire logic pme_n_i,
    input wire logic serial_ri_i,
    input wire swpc_pkg::swpc_cmd_type cmd_i,
    input wire logic cmd_valid_i,
    input wire logic soft_off_en_i,
    input wire logic ring_first_call_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nap;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Either ACPI sleeping state that wakes on activity
    assign nap = (pstate_o == SWPC_S1) || (pstate_o == SWPC_S3);
    property p_s3_dark;
        (pstate_o == SWPC_S3) [*3] |-> psu_on_n_o && !sys_fan_on_o
            && !psu_fan_on_o && (led_amber_o == led_dual_i);
    endproperty
    a_s3_dark: assert property (p_s3_dark) else $error("lit in S3");
    property p_lan_s3;
        pstate_o == SWPC_S3 && $fell(lan_wake_n_i)
            |=> (pstate_o == SWPC_S3) [*6];
    endproperty
    a_lan_s3: assert property (p_lan_s3) else $error("woke from S3");
    property p_usb;
        nap && $rose(usb_wake_i) |-> ##[1:10] pstate_o == SWPC_S0;
    endproperty
    a_usb: assert property (p_usb) else $error("usb wake lost");
    property p_kbd;
        nap && $rose(kbd_wake_i) |-> ##[1:10] pstate_o == SWPC_S0;
    endproperty
    a_kbd: assert property (p_kbd) else $error("kbd wake lost");
    property p_pme;
        nap && $fell(pme_n_i) |-> ##[1:10] pstate_o == SWPC_S0;
    endproperty
    a_pme: assert property (p_pme) else $error("pme wake lost");
    property p_s1_ring;
        pstate_o == SWPC_S1 && $rose(serial_ri_i)
            |-> ##[1:10] pstate_o == SWPC_S0;
    endproperty
    a_s1_ring: assert property (p_s1_ring) else $error("no resume");
    property p_ring_flag;
        pstate_o == SWPC_S3 && ext_modem_i && $rose(serial_ri_i)
            |-> ##[1:10] ring_first_call_o;
    endproperty
    a_ring_flag: assert property (p_ring_flag) else $error("no flag");
    property p_soft_off;
        pstate_o == SWPC_S0 && cmd_valid_i && cmd_i == SWPC_CMD_OFF
            && soft_off_en_i |-> ##[1:4] psu_on_n_o;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("still on");
    // Main scenarios reached
    c_s3_wake: cover property (pstate_o == SWPC_S3
        ##[1:20] pstate_o == SWPC_S0);
    c_apm_sleep: cover property (pstate_o == SWPC_APM_SLEEP);
    c_restore: cover property (pstate_o == SWPC_G3 ##1 pstate_o != SWPC_G3);
    c_on: cover property ($fell(psu_on_n_o));
endmodule

bind swpc_core swpc_checker swpc_checker_inst (
    .clk_sys_i, .resetn_i, .pstate_o, .psu_on_n_o, .sys_fan_on_o,
    .psu_fan_on_o, .led_amber_o, .led_dual_i, .ext_modem_i, .lan_wake_n_i,
    .usb_wake_i, .kbd_wake_i, .pme_n_i, .serial_ri_i, .cmd_i, .cmd_valid_i,
    .soft_off_en_i, .ring_first_call_o
);

// ### test/swpc_partner.sv
// Model of the supply, fans and network wake lines around the sequencer.
// Assumes the bench clock; wake lines are open drain with pull-ups.
module swpc_partner (
    input wire logic clk_sys_i,
    input wire logic ac_present_i,
    input wire logic psu_on_n_i,
    input wire logic sys_fan_on_i,
    input wire logic psu_fan_on_i,
    input wire logic lan_req_i,
    input wire logic pme_req_i,
    output logic power_good_o,
    output logic sys_fan_tach_o,
    output logic psu_fan_tach_o,
    output logic lan_wake_n_o,
    output logic pme_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] spin = 4'h0;
    logic [1:0] rise = 2'h0;
    // Good comes late after switch-on, drops at the next clock on loss
    always @(posedge clk_sys_i) begin
        rise <= (psu_on_n_i || !ac_present_i) ? 2'h0 : {rise[0], 1'h1};
        spin <= spin + 4'h1;
    end
    assign power_good_o = rise[1];
    // Tach pulses only while the fan is powered
    assign sys_fan_tach_o = sys_fan_on_i & spin[1];
    assign psu_fan_tach_o = psu_fan_on_i & spin[2];
    assign lan_wake_n_o = !lan_req_i;
    assign pme_n_o = !pme_req_i;
endmodule

// ### test/testbench.sv
// Self-checking bench for the wake and power sequencer.
// Assumes long-press and settle counts shortened by parameter.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import swpc_pkg::*;
    logic clk_sys_i = 1'h0, resetn_i = 1'h0, ac_present_i = 1'h0;
    logic soft_off_en_i = 1'h1, cmd_valid_i = 1'h0, acpi_mode_i = 1'h1;
    logic led_dual_i = 1'h1, ext_modem_i = 1'h1, pwr_btn_n_i = 1'h1;
    logic ring_wake_n_i = 1'h1, serial_ri_i = 1'h0, usb_wake_i = 1'h0;
    logic kbd_wake_i = 1'h0, lan_req = 1'h0, pme_req = 1'h0;
    logic power_good, lan_wake_n, pme_n, sys_tach, psu_tach;
    logic psu_on_n_o, sys_fan_on_o, psu_fan_on_o, led_green_o, led_amber_o;
    logic sys_running_o, ring_first_call_o, sys_fan_tach_o, psu_fan_tach_o;
    swpc_cmd_type cmd_i = SWPC_CMD_NONE;
    swpc_pstate_type pstate_o;
    int err_count = 0, tests_run = 0;
    swpc_core #(.LONG_PRESS_CYC(32'h14), .SETTLE_CYC(32'h5)) swpc_core_inst (
        .clk_sys_i, .resetn_i, .soft_off_en_i, .ac_present_i,
        .power_good_i(power_good), .cmd_i, .cmd_valid_i, .acpi_mode_i,
        .led_dual_i, .ext_modem_i, .pwr_btn_n_i, .lan_wake_n_i(lan_wake_n),
        .serial_ri_i, .ring_wake_n_i, .usb_wake_i, .kbd_wake_i,
        .pme_n_i(pme_n), .rtc_alarm_i(1'h0), .sys_fan_tach_i(sys_tach),
        .psu_fan_tach_i(psu_tach), .psu_on_n_o, .sys_fan_on_o, .psu_fan_on_o,
        .led_green_o, .led_amber_o, .sys_running_o, .ring_first_call_o,
        .sys_fan_tach_o, .psu_fan_tach_o, .pstate_o);
    swpc_partner swpc_partner_inst (
        .clk_sys_i, .ac_present_i, .psu_on_n_i(psu_on_n_o),
        .sys_fan_on_i(sys_fan_on_o), .psu_fan_on_i(psu_fan_on_o),
        .lan_req_i(lan_req), .pme_req_i(pme_req), .power_good_o(power_good),
        .sys_fan_tach_o(sys_tach), .psu_fan_tach_o(psu_tach),
        .lan_wake_n_o(lan_wake_n), .pme_n_o(pme_n));
    // Free-running 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Bounded wait for a state; running out ends the run
    task automatic wait_st(input swpc_pstate_type t);
        int i;
        for (i = 0; i < 300 && pstate_o !== t; i++) cyc(1);
        chk({5'h0, pstate_o}, {5'h0, t});
        if (pstate_o !== t) begin
            print_verdict();
        end
    endtask
    // Wake source k: usb, kbd, pme, serial ring, ring connector, lan
    task automatic set_src(input int k, input logic v);
        case (k)
            0: usb_wake_i <= v;
            1: kbd_wake_i <= v;
            2: pme_req <= v;
            3: serial_ri_i <= v;
            4: ring_wake_n_i <= !v;
            default: lan_req <= v;
        endcase
    endtask
    task automatic pulse(input int k);
        set_src(k, 1'h1);
        cyc(4);
        set_src(k, 1'h0);
        cyc(1);
    endtask
    // Settle in the working state first, then a one-cycle strobe
    task automatic send(input swpc_cmd_type c);
        cyc(8);
        cmd_i <= c;
        cmd_valid_i <= 1'h1;
        cyc(1);
        cmd_valid_i <= 1'h0;
        cyc(1);
    endtask
    task automatic press(input int n);
        cyc(8);
        pwr_btn_n_i <= 1'h0;
        cyc(n);
        pwr_btn_n_i <= 1'h1;
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    function automatic swpc_pstate_type off_st(input logic acpi);
        return acpi ? SWPC_S5 : SWPC_APM_OFF;
    endfunction
    // Main sequence
    initial begin
        int i, k, base;
        void'($urandom(9493));
        cyc(6);
        resetn_i <= 1'h1;
        cyc(2);
        ac_present_i <= 1'h1;
        wait_st(off_st(acpi_mode_i));
        pulse(5);
        wait_st(SWPC_S0);
        cyc(12);
        chk({5'h0, psu_on_n_o, sys_fan_on_o, psu_fan_on_o}, 8'h03);
        chk({6'h0, sys_running_o, led_green_o}, 8'h03);
        // Tach toggles every two cycles while the fan runs
        k = sys_fan_tach_o;
        cyc(2);
        chk({7'h0, sys_fan_tach_o}, {7'h0, !k[0]});
        done("power on");
        base = $urandom % 4;
        for (i = 0; i < 4; i++) begin
            k = (base + i) % 4;
            led_dual_i <= 1'($urandom);
            send(SWPC_CMD_S3);
            wait_st(SWPC_S3);
            cyc(3);
            chk({5'h0, psu_on_n_o, sys_fan_on_o, psu_fan_on_o}, 8'h04);
            chk({6'h0, led_green_o, led_amber_o}, {7'h0, led_dual_i});
            chk({6'h0, sys_fan_tach_o, psu_fan_tach_o}, 8'h00);
            pulse(5);
            chk({5'h0, pstate_o}, {5'h0, SWPC_S3});
            pulse(k);
            wait_st(SWPC_S0);
            cyc(2);
            chk({7'h0, ring_first_call_o}, {7'h0, k == 3});
        end
        done("suspend wakes");
        ext_modem_i <= 1'h0;
        send(SWPC_CMD_S3);
        wait_st(SWPC_S3);
        pulse(3);
        chk({5'h0, pstate_o}, {5'h0, SWPC_S3});
        pulse(4);
        wait_st(SWPC_S0);
        cyc(2);
        chk({7'h0, ring_first_call_o}, 8'h01);
        done("ring connector");
        for (k = 0; k < 4; k++) begin
            send(SWPC_CMD_S1);
            wait_st(SWPC_S1);
            pulse(k);
            wait_st(SWPC_S0);
        end
        done("light sleep");
        soft_off_en_i <= 1'h0;
        send(SWPC_CMD_OFF);
        cyc(4);
        chk({5'h0, pstate_o}, {5'h0, SWPC_S0});
        soft_off_en_i <= 1'h1;
        send(SWPC_CMD_OFF);
        wait_st(SWPC_S5);
        cyc(2);
        chk({7'h0, psu_on_n_o}, 8'h01);
        done("soft off");
        ac_present_i <= 1'h0;
        wait_st(SWPC_G3);
        ac_present_i <= 1'h1;
        wait_st(SWPC_S5);
        pulse(5);
        wait_st(SWPC_S0);
        cyc(10);
        ac_present_i <= 1'h0;
        wait_st(SWPC_G3);
        ac_present_i <= 1'h1;
        wait_st(SWPC_S0);
        done("outage");
        press(3 + $urandom % 10);
        wait_st(SWPC_S1);
        pulse(1);
        wait_st(SWPC_S0);
        press(25 + $urandom % 10);
        wait_st(SWPC_S5);
        done("power switch");
        pulse(5);
        wait_st(SWPC_S0);
        acpi_mode_i <= 1'h0;
        send(SWPC_CMD_OFF);
        wait_st(off_st(acpi_mode_i));
        pulse(4);
        wait_st(SWPC_S0);
        cyc(2);
        chk({7'h0, ring_first_call_o}, 8'h01);
        send(SWPC_CMD_APM_SLEEP);
        wait_st(SWPC_APM_SLEEP);
        pulse(3);
        wait_st(SWPC_S0);
        done("legacy off");
        print_verdict();
    end
endmodule
